// file: verilog/rtm_pkg.sv
package rtm_pkg;
  localparam int CNT_W = 32;
  localparam int NUM_CH = 3;
  localparam int DIV_W = 8;
  localparam logic [31:0] CNT_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] RELOAD_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] CAPT_RST = 32'h0000_0000;
  localparam logic [7:0] DIV_RST = 8'h00;
  // Count clock select codes
  localparam logic [2:0] CS_DIV4 = 3'h0;
  localparam logic [2:0] CS_DIV16 = 3'h1;
  localparam logic [2:0] CS_DIV64 = 3'h2;
  localparam logic [2:0] CS_DIV256 = 3'h3;
  localparam logic [2:0] CS_EXT = 3'h5;
  // Divider terminal masks: tick when the low bits are all ones
  localparam logic [7:0] DIV4_MASK = 8'h03;
  localparam logic [7:0] DIV16_MASK = 8'h0F;
  localparam logic [7:0] DIV64_MASK = 8'h3F;
  localparam logic [7:0] DIV256_MASK = 8'hFF;
  // Edge select codes
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  // Capture control codes
  localparam logic [1:0] CAPT_IRQ = 2'h3;
  localparam int CAPT_EN_BIT = 1;
endpackage

// file: verilog/rtm_chan_if.sv
`timescale 1ns/1ps
interface rtm_chan_if;
  import rtm_pkg::*;
  logic run;
  logic [2:0] clk_sel;
  logic [1:0] edge_sel;
  logic cnt_we;
  logic reload_we;
  logic [CNT_W-1:0] wdata;
  logic flag_we;
  logic flag_wval;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] reload;
  logic uf_flag;
  modport chan (
    input run, clk_sel, edge_sel, cnt_we, reload_we, wdata, flag_we, flag_wval,
    output cnt, reload, uf_flag
  );
  modport ctrl (
    output run, clk_sel, edge_sel, cnt_we, reload_we, wdata, flag_we, flag_wval,
    input cnt, reload, uf_flag
  );
endinterface

// file: verilog/rtm_chan.sv
`timescale 1ns/1ps
module rtm_chan
  import rtm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] div_tick,
  input wire logic ext_rise,
  input wire logic ext_fall,
  rtm_chan_if.chan bus
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] reload;
    logic uf_flag;
  } rtm_chan_s;

  rtm_chan_s st_ff;
  rtm_chan_s nxt_st;
  logic ext_tick;
  logic tick;

  // Source select; prohibited codes never tick
  always_comb begin
    case (bus.edge_sel)
      EDGE_RISE: ext_tick = ext_rise; // [RQ19]
      EDGE_FALL: ext_tick = ext_fall;
      default: ext_tick = ext_rise | ext_fall; // [RQ7]
    endcase
    case (bus.clk_sel)
      CS_DIV4: tick = div_tick[0]; // [RQ6] [RQ18]
      CS_DIV16: tick = div_tick[1];
      CS_DIV64: tick = div_tick[2];
      CS_DIV256: tick = div_tick[3];
      CS_EXT: tick = ext_tick;
      default: tick = 1'b0;
    endcase
    tick = tick & bus.run; // [RQ2] [RQ22]
  end

  // Count, reload and flag update
  always_comb begin
    nxt_st = st_ff;
    if (tick) begin
      if (st_ff.cnt == '0) begin
        nxt_st.cnt = st_ff.reload; // [RQ5]
      end else begin
        nxt_st.cnt = st_ff.cnt - 1'b1; // [RQ1]
      end
    end
    // Writes win over counting; software halts the channel first anyway [RQ16]
    if (bus.cnt_we) begin
      nxt_st.cnt = bus.wdata;
    end
    if (bus.reload_we) begin
      nxt_st.reload = bus.wdata;
    end
    // Writing 1 keeps the flag; a same-cycle underflow beats a clear
    if (bus.flag_we && !bus.flag_wval) begin
      nxt_st.uf_flag = 1'b0; // [RQ13]
    end
    if (tick && st_ff.cnt == '0) begin
      nxt_st.uf_flag = 1'b1; // [RQ3]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{cnt: CNT_RST, reload: RELOAD_RST, uf_flag: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.cnt = st_ff.cnt;
  assign bus.reload = st_ff.reload;
  assign bus.uf_flag = st_ff.uf_flag;

  property p_reload;
    @(posedge clk) disable iff (!rst_n)
    (tick && st_ff.cnt == '0 && !bus.cnt_we) |=> (st_ff.cnt == $past(st_ff.reload) && st_ff.uf_flag);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload at underflow"); // [RQ5]

  property p_dec;
    @(posedge clk) disable iff (!rst_n)
    (tick && st_ff.cnt != '0 && !bus.cnt_we) |=> st_ff.cnt == $past(st_ff.cnt) - 32'h0000_0001;
  endproperty
  a_dec: assert property (p_dec) else $error("count did not decrement"); // [RQ1]

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    (!bus.run && !bus.cnt_we && !bus.flag_we) |=> ($stable(st_ff.cnt) && $stable(st_ff.uf_flag));
  endproperty
  a_hold: assert property (p_hold) else $error("stopped channel changed"); // [RQ22]

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
    (bus.flag_we && !bus.flag_wval && !tick) |=> !st_ff.uf_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared by 0"); // [RQ13]

  property p_keep;
    @(posedge clk) disable iff (!rst_n)
    (bus.flag_we && bus.flag_wval && st_ff.uf_flag) |=> st_ff.uf_flag;
  endproperty
  a_keep: assert property (p_keep) else $error("writing 1 disturbed flag"); // [RQ13]
endmodule // rtm_chan

// file: verilog/rtm_top.sv
`timescale 1ns/1ps
// Behaviour
// [RQ1] Three channels, each a 32-bit down counter and 32-bit reload constant.
// [RQ2] A channel counts only after its run bit is set.
// [RQ3] Underflow sets the channel's underflow flag.
// [RQ4] Underflow requests an interrupt when the channel's enable bit is 1.
// [RQ5] Underflow loads the reload constant and counting continues from it.
// [RQ6] Internal count clocks are the clock divided by 4, 16, 64 or 256.
// [RQ7] External pin counting on rising, falling or both edges.
// [RQ8] Pin pulses last 2 clocks single edge, 3 clocks both edges.
// [RQ9] Software picks an internal clock for channel 2 when capturing.
// [RQ10] Capture copies channel 2's count on the chosen pin edge.
// [RQ11] Capture is inert during standby.
// [RQ12] Sources: underflow per channel, plus channel 2 capture.
// [RQ13] Writing 0 clears a flag; writing 1 leaves it.
// [RQ14] A request stands only while flag and enable are both 1.
// [RQ15] Priority: ch0, ch1, ch2 underflow, then capture lowest.
// [RQ16] Software halts a channel before writing its registers.
// [RQ17] A read during a decrement returns the value before it.
// [RQ18] Clock select 000..011 are the divisors, 101 the pin, rest none.
// [RQ19] Edge select 00 rising, 01 falling, 1X both.
// [RQ20] Capture control 00 off, 01 prohibited, 10 on, 11 on with interrupt.
// [RQ21] A capture sets channel 2's capture flag, source of its interrupt.
// [RQ22] A stopped channel holds its count and flag.
module rtm_top
  import rtm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_clock_capture_pin,
  input wire logic standby,
  input wire logic [NUM_CH-1:0] run_control_register,
  input wire logic [NUM_CH*3-1:0] count_clock_sel,
  input wire logic [NUM_CH*2-1:0] edge_sel,
  input wire logic [NUM_CH-1:0] underflow_irq_enable,
  input wire logic [1:0] capture_ctrl,
  input wire logic [CNT_W-1:0] wr_data,
  input wire logic [NUM_CH-1:0] wr_counter,
  input wire logic [NUM_CH-1:0] wr_reload,
  input wire logic [NUM_CH-1:0] wr_underflow_flag,
  input wire logic wr_capture_flag,
  output logic [NUM_CH*CNT_W-1:0] down_counter,
  output logic [NUM_CH*CNT_W-1:0] reload_constant,
  output logic [NUM_CH-1:0] underflow_flag,
  output logic capture_flag,
  output logic [CNT_W-1:0] capture_register_ch2,
  output logic underflow_irq_ch0,
  output logic underflow_irq_ch1,
  output logic underflow_irq_ch2,
  output logic capture_irq_ch2,
  output logic [3:0] irq_grant
);
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic pin_prev;
    logic [CNT_W-1:0] capt;
    logic capt_flag;
    logic [3:0] irq;
    logic [3:0] grant;
  } rtm_top_s;

  rtm_top_s st_ff;
  rtm_top_s nxt_st;
  logic [3:0] div_tick;
  logic ext_rise;
  logic ext_fall;
  logic capt_edge;
  logic capt_hit;
  logic [3:0] req;
  logic [CNT_W-1:0] cnt2;

  // Prescaler taps and pin edges from the held previous level
  always_comb begin
    div_tick[0] = (st_ff.div & DIV4_MASK) == DIV4_MASK; // [RQ6]
    div_tick[1] = (st_ff.div & DIV16_MASK) == DIV16_MASK;
    div_tick[2] = (st_ff.div & DIV64_MASK) == DIV64_MASK;
    div_tick[3] = (st_ff.div & DIV256_MASK) == DIV256_MASK;
    ext_rise = ext_clock_capture_pin & ~st_ff.pin_prev;
    ext_fall = ~ext_clock_capture_pin & st_ff.pin_prev;
  end

  // One channel instance per timer; all share prescaler and pin edges
  for (genvar g = 0; g < NUM_CH; g++) begin : gen_ch
    rtm_chan_if ch_if ();
    assign ch_if.run = run_control_register[g];
    assign ch_if.clk_sel = count_clock_sel[g*3 +: 3];
    assign ch_if.edge_sel = edge_sel[g*2 +: 2];
    assign ch_if.cnt_we = wr_counter[g];
    assign ch_if.reload_we = wr_reload[g];
    assign ch_if.wdata = wr_data;
    assign ch_if.flag_we = wr_underflow_flag[g];
    assign ch_if.flag_wval = wr_data[0];
    rtm_chan u_chan (
      .clk(clk),
      .rst_n(rst_n),
      .div_tick(div_tick),
      .ext_rise(ext_rise),
      .ext_fall(ext_fall),
      .bus(ch_if.chan)
    );
    // Counter read path is the register itself, so a read never sees a half step
    assign down_counter[g*CNT_W +: CNT_W] = ch_if.cnt; // [RQ17]
    assign reload_constant[g*CNT_W +: CNT_W] = ch_if.reload;
    assign underflow_flag[g] = ch_if.uf_flag;
  end

  assign cnt2 = down_counter[2*CNT_W +: CNT_W];

  // Capture edge selection and standby gate
  always_comb begin
    case (edge_sel[5:4])
      EDGE_RISE: capt_edge = ext_rise; // [RQ19]
      EDGE_FALL: capt_edge = ext_fall;
      default: capt_edge = ext_rise | ext_fall;
    endcase
    // Code 01 is prohibited and treated as off
    capt_hit = capt_edge & capture_ctrl[CAPT_EN_BIT] & ~standby; // [RQ20] [RQ11]
    req[0] = underflow_flag[0] & underflow_irq_enable[0]; // [RQ4] [RQ14]
    req[1] = underflow_flag[1] & underflow_irq_enable[1];
    req[2] = underflow_flag[2] & underflow_irq_enable[2];
    req[3] = st_ff.capt_flag & (capture_ctrl == CAPT_IRQ); // [RQ12]
  end

  // State update
  always_comb begin
    nxt_st = st_ff;
    nxt_st.div = st_ff.div + 1'b1;
    nxt_st.pin_prev = ext_clock_capture_pin;
    if (capt_hit) begin
      nxt_st.capt = cnt2; // [RQ10]
    end
    if (wr_capture_flag && !wr_data[0]) begin
      nxt_st.capt_flag = 1'b0; // [RQ13]
    end
    if (capt_hit) begin
      nxt_st.capt_flag = 1'b1; // [RQ21]
    end
    nxt_st.irq = req;
    // Fixed priority grant, lowest index wins
    nxt_st.grant = req & (~req + 4'h1); // [RQ15]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{div: DIV_RST, pin_prev: 1'b0, capt: CAPT_RST, capt_flag: 1'b0,
                 irq: 4'h0, grant: 4'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign capture_flag = st_ff.capt_flag;
  assign capture_register_ch2 = st_ff.capt;
  assign underflow_irq_ch0 = st_ff.irq[0];
  assign underflow_irq_ch1 = st_ff.irq[1];
  assign underflow_irq_ch2 = st_ff.irq[2];
  assign capture_irq_ch2 = st_ff.irq[3];
  assign irq_grant = st_ff.grant;

  property p_irq;
    @(posedge clk) disable iff (!rst_n)
    ##1 underflow_irq_ch1 == $past(underflow_flag[1] && underflow_irq_enable[1]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq not flag and enable"); // [RQ14]

  property p_capt;
    @(posedge clk) disable iff (!rst_n)
    capt_hit |=> (capture_register_ch2 == $past(cnt2) && capture_flag);
  endproperty
  a_capt: assert property (p_capt) else $error("capture missed"); // [RQ10]

  property p_standby;
    @(posedge clk) disable iff (!rst_n)
    (standby && !(wr_capture_flag && !wr_data[0])) |=> ($stable(capture_register_ch2)
      && capture_flag == $past(capture_flag));
  endproperty
  a_standby: assert property (p_standby) else $error("capture during standby"); // [RQ11]

  // Channel 0 wins whatever else is pending
  property p_prio;
    @(posedge clk) disable iff (!rst_n)
    req[0] |=> irq_grant == 4'h1;
  endproperty
  a_prio: assert property (p_prio) else $error("priority order wrong"); // [RQ15]

  property p_prio_mid;
    @(posedge clk) disable iff (!rst_n)
    (req[1] && !req[0]) |=> irq_grant == 4'h2;
  endproperty
  a_prio_mid: assert property (p_prio_mid) else $error("channel 1 not granted"); // [RQ15]

  // Capture is granted only when no underflow is pending
  property p_prio_low;
    @(posedge clk) disable iff (!rst_n)
    (req[3] && req[2:0] == 3'h0) |=> irq_grant == 4'h8;
  endproperty
  a_prio_low: assert property (p_prio_low) else $error("capture not granted"); // [RQ15]

  property p_div4;
    @(posedge clk) disable iff (!rst_n)
    div_tick[0] |=> !div_tick[0] ##1 !div_tick[0] ##1 !div_tick[0] ##1 div_tick[0];
  endproperty
  a_div4: assert property (p_div4) else $error("divide by 4 period wrong"); // [RQ6]

  property p_irq0;
    @(posedge clk) disable iff (!rst_n)
    ##1 underflow_irq_ch0 == $past(underflow_flag[0] && underflow_irq_enable[0]);
  endproperty
  a_irq0: assert property (p_irq0) else $error("irq0 not flag and enable"); // [RQ4]

  property p_irq2;
    @(posedge clk) disable iff (!rst_n)
    ##1 underflow_irq_ch2 == $past(underflow_flag[2] && underflow_irq_enable[2]);
  endproperty
  a_irq2: assert property (p_irq2) else $error("irq2 not flag and enable"); // [RQ4]

  // Capture request only with flag set and the interrupt code selected
  property p_cirq;
    @(posedge clk) disable iff (!rst_n)
    ##1 capture_irq_ch2 == $past(capture_flag && capture_ctrl == CAPT_IRQ);
  endproperty
  a_cirq: assert property (p_cirq) else $error("capture irq not flag and enable"); // [RQ12]

  // Off and prohibited codes must ignore pin edges
  property p_capt_off;
    @(posedge clk) disable iff (!rst_n)
    (capt_edge && !capture_ctrl[CAPT_EN_BIT]) |=> ($stable(capture_register_ch2)
      && !$rose(capture_flag));
  endproperty
  a_capt_off: assert property (p_capt_off) else $error("capture while disabled"); // [RQ20]
endmodule // rtm_top

// file: bench/rtm_pulse_src.sv
`timescale 1ns/1ps
// Pulse source on the count/capture pin; idles low between bursts
module rtm_pulse_src (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [7:0] n_pulses,
  input wire logic [3:0] width,
  output logic pin,
  output logic busy
);
  logic [7:0] left;
  logic [3:0] cnt;
  logic [3:0] w;
  // Never under 3 clocks, so both-edge counting stays legal too
  assign w = (width < 4'h3) ? 4'h3 : width;
  // Toggle every w clocks until the burst is out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin <= 1'b0;
      busy <= 1'b0;
      left <= 8'h00;
      cnt <= 4'h0;
    end else if (go && !busy) begin
      left <= n_pulses;
      cnt <= 4'h0;
      busy <= 1'b1;
    end else if (busy) begin
      cnt <= cnt + 4'h1;
      if (cnt == w - 4'h1) begin
        cnt <= 4'h0;
        pin <= ~pin;
        if (pin) begin
          left <= left - 8'h01;
          busy <= (left != 8'h01);
        end
      end
    end
  end
endmodule // rtm_pulse_src

// file: bench/three_channel_reload_down_timer_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module three_channel_reload_down_timer_bench;
  import rtm_pkg::*;
  logic clk = 0;
  logic rst_n = 0;
  logic stb = 0;
  logic [2:0] run = 0;
  logic [8:0] csel = 0;
  logic [5:0] esel = 0;
  logic [2:0] ien = 0;
  logic [1:0] cctl = 0;
  logic [31:0] wd = 0;
  logic [2:0] wcn = 0;
  logic [2:0] wrl = 0;
  logic [2:0] wuf = 0;
  logic wcf = 0;
  logic go = 0;
  logic [7:0] npl = 1;
  logic [3:0] pw = 3;
  logic pin, busy, cflag, cirq, i0, i1, i2;
  logic [95:0] cnt, rel;
  logic [2:0] uf;
  logic [31:0] capr, v;
  logic [31:0] r [3];
  logic [3:0] grant;
  int failures = 0;
  int n_checks = 0;
  int cyc_n = 0;
  int n;

  always #25 clk = ~clk;

  rtm_top u_dut (.clk(clk), .rst_n(rst_n), .ext_clock_capture_pin(pin), .standby(stb),
    .run_control_register(run), .count_clock_sel(csel), .edge_sel(esel),
    .underflow_irq_enable(ien), .capture_ctrl(cctl), .wr_data(wd), .wr_counter(wcn),
    .wr_reload(wrl), .wr_underflow_flag(wuf), .wr_capture_flag(wcf), .down_counter(cnt),
    .reload_constant(rel), .underflow_flag(uf), .capture_flag(cflag),
    .capture_register_ch2(capr), .underflow_irq_ch0(i0), .underflow_irq_ch1(i1),
    .underflow_irq_ch2(i2), .capture_irq_ch2(cirq), .irq_grant(grant));

  rtm_pulse_src u_src (.clk(clk), .rst_n(rst_n), .go(go), .n_pulses(npl), .width(pw),
    .pin(pin), .busy(busy));

  task automatic stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Inputs move 2 ns after the edge, clear of sampling
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask

  // Strobe then an idle cycle, so strobes never re-assert in one step
  task automatic wr(input int kind, input int g, input logic [31:0] d);
    wd = d;
    case (kind)
      0: wcn[g] = 1;
      1: wrl[g] = 1;
      2: wuf[g] = 1;
      default: wcf = 1;
    endcase
    cyc(1);
    {wcn, wrl, wuf, wcf} = '0;
    cyc(1);
  endtask

  task automatic pulse(input int k, input int w);
    npl = k[7:0];
    pw = w[3:0];
    go = 1;
    cyc(1);
    go = 0;
    for (int i = 0; i < 200 && busy; i++) cyc(1);
    cyc(4);
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n > 20000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    void'($urandom(26437));
    cyc(2);
    rst_n = 1;
    cyc(1);
    for (int g = 0; g < 3; g++) begin
      `CHK(cnt[g*32+:32], CNT_RST)
      `CHK(rel[g*32+:32], RELOAD_RST)
    end
    cyc(20);
    `CHK(cnt[31:0], CNT_RST)
    // Any window of 3*div clocks holds exactly 3 ticks; code 4 must not count
    for (int c = 0; c < 5; c++) begin
      v = $urandom | 32'h0000_0100;
      wr(0, 0, v);
      csel[2:0] = c[2:0];
      run[0] = 1;
      cyc(c < 4 ? 3 * (4 << (2 * c)) : 64);
      run[0] = 0;
      cyc(2);
      `CHK(cnt[31:0], v - (c < 4 ? 32'h3 : 32'h0))
      `CHK(uf, 3'h0)
    end
    // All three underflow together, then flags cleared one by one
    for (int g = 0; g < 3; g++) begin
      r[g] = $urandom | 32'h0001_0000;
      wr(1, g, r[g]);
      wr(0, g, 32'h0);
    end
    csel = {CS_DIV4, CS_DIV4, CS_DIV4};
    ien = 3'h7;
    run = 3'h7;
    for (int i = 0; i < 10 && uf !== 3'h7; i++) cyc(1);
    run = 0;
    cyc(3);
    `CHK(uf, 3'h7)
    for (int g = 0; g < 3; g++) `CHK(cnt[g*32+:32], r[g])
    `CHK({i2, i1, i0}, 3'h7)
    `CHK(grant, 4'h1)
    wr(2, 0, 32'h1);
    `CHK(uf, 3'h7)
    wr(2, 0, 32'h0);
    cyc(2);
    `CHK({i2, i1, i0}, 3'h6)
    `CHK(grant, 4'h2)
    ien[1] = 0;
    cyc(3);
    `CHK({i2, i1, i0}, 3'h4)
    `CHK(grant, 4'h4)
    wr(2, 1, 32'h0);
    wr(2, 2, 32'h0);
    `CHK(uf, 3'h0)
    // Pin counting under every edge code
    csel[2:0] = CS_EXT;
    for (int e = 0; e < 4; e++) begin
      v = $urandom | 32'h0000_0100;
      wr(0, 0, v);
      esel[1:0] = e[1:0];
      n = 1 + $urandom % 5;
      run[0] = 1;
      pulse(n, 3 + $urandom % 3);
      run[0] = 0;
      `CHK(cnt[31:0], v - (e > 1 ? 2 * n : n))
    end
    // Capture with channel 2 halted, so the captured count is exact
    csel[8:6] = CS_DIV4;
    for (int c = 0; c < 4; c++) begin
      v = $urandom;
      wr(0, 2, v);
      cctl = c[1:0];
      esel[5:4] = 2'($urandom);
      pulse(1, 3);
      `CHK(cflag, c[1])
      `CHK(cirq, c == 3)
      `CHK(grant, c == 3 ? 4'h8 : 4'h0)
      if (c[1]) `CHK(capr, v)
      wr(3, 0, 32'h0);
    end
    stb = 1;
    wr(0, 2, ~v);
    pulse(1, 3);
    `CHK(cflag, 1'b0)
    `CHK(capr, v)
    stop_test();
  end
endmodule // three_channel_reload_down_timer_bench
